// ==== include/card_rd_dma_params.svh ====
`ifndef CARD_RD_DMA_PARAMS_SVH
`define CARD_RD_DMA_PARAMS_SVH

// Register bus geometry
`define CRD_ADDR_W          8
`define CRD_DATA_W          32

// Register offsets (byte addresses)
`define CRD_OFS_MODE        8'h00
`define CRD_OFS_DMA         8'h04
`define CRD_OFS_ARG         8'h08
`define CRD_OFS_CMD         8'h0c
`define CRD_OFS_STATUS      8'h10
`define CRD_OFS_FIFO        8'h14

// Mode register fields
`define CRD_MODE_LEN_LSB    0
`define CRD_MODE_LEN_W      16
`define CRD_MODE_PROOF_BIT  16

// DMA configuration register fields
`define CRD_DMA_OFS_LSB     0
`define CRD_DMA_CHUNK_LSB   4
`define CRD_DMA_CHUNK_W     3
`define CRD_DMA_EN_BIT      8
`define CRD_DMA_READ_ROUND_OPTION_BIT    12

// Command register fields
`define CRD_CMD_IDX_W       6
`define CRD_CMD_READ_BIT    8

// Status register bits
`define CRD_ST_COMMAND_READY_FLAG_BIT   0
`define CRD_ST_IDLE_BIT     1
`define CRD_ST_DONE_BIT     2
`define CRD_ST_EMPTY_BIT    3
`define CRD_ST_OVR_BIT      4
`define CRD_ST_REQ_BIT      5

// Receive FIFO depth as address width (16 words)
`define CRD_FIFO_AW         4

// Reset values
`define CRD_RST_CMD_READY   1'b1
`define CRD_RST_CARD_IDLE   1'b1

`endif

// ==== include/card_rd_dma_pkg.sv ====
package card_rd_dma_pkg;

`include "card_rd_dma_params.svh"

    // Software configuration of the read path
    typedef struct packed {
        logic [`CRD_MODE_LEN_W-1:0]  blk_len;
        logic                        read_stall_proof;
        logic [1:0]                  dma_offset;
        logic [`CRD_DMA_CHUNK_W-1:0] dma_chunk_size;
        logic                        dma_handshake_enable;
        logic                        read_round_option;
    } host_cfg_t;

    // State of the card host read path, apart from the receive FIFO
    typedef struct packed {
        host_cfg_t                   cfg;
        logic [31:0]                 cmd_arg;
        logic [`CRD_CMD_IDX_W-1:0]   cmd_index;
        logic                        cmd_start;
        logic                        command_ready_flag;
        logic                        card_idle_flag;
        logic                        transfer_done_flag;
        logic                        overrun_flag;
        logic                        rx_active;
        logic [`CRD_MODE_LEN_W-1:0]  rx_bytes;
        logic [31:0]                 pack_data;
        logic [1:0]                  pack_cnt;
        logic [1:0]                  byte_idx;
        logic [`CRD_DATA_W-1:0]      rdata;
    } host_state_t;

endpackage : card_rd_dma_pkg

// ==== rtl/card_rx_fifo.sv ====
`timescale 1ns/100ps

module card_rx_fifo #(
    parameter int W  = 32,
    parameter int AW = 4
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    // Control
    input  wire logic          flush_i,
    input  wire logic          push_i,
    input  wire logic [W-1:0]  push_data_i,
    input  wire logic          pop_i,
    // Status and head word
    output logic [W-1:0]       data_o,
    output logic [AW:0]        count_o,
    output logic               full_o,
    output logic               empty_o
);

    typedef struct packed {
        logic [(1<<AW)-1:0][W-1:0] mem;
        logic [AW-1:0]             wr_ptr;
        logic [AW-1:0]             rd_ptr;
        logic [AW:0]               count;
    } fifo_state_t;

    fifo_state_t st_ff;
    fifo_state_t nxt_ff;
    logic        do_push;
    logic        do_pop;

    // Status straight from the occupancy count
    assign full_o  = st_ff.count[AW];
    assign empty_o = (st_ff.count == '0);
    assign count_o = st_ff.count;
    assign data_o  = st_ff.mem[st_ff.rd_ptr];

    // Refuse a push when full and a pop when empty
    always_comb
    begin
        nxt_ff  = st_ff;
        do_push = push_i && !full_o;
        do_pop  = pop_i && !empty_o;
        if (do_push)
        begin
            nxt_ff.mem[st_ff.wr_ptr] = push_data_i;
            nxt_ff.wr_ptr            = st_ff.wr_ptr + 1'b1;
        end
        if (do_pop)
        begin
            nxt_ff.rd_ptr = st_ff.rd_ptr + 1'b1;
        end
        nxt_ff.count = st_ff.count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
        // Flush drops leftovers of an aborted block
        if (flush_i)
        begin
            nxt_ff.wr_ptr = '0;
            nxt_ff.rd_ptr = '0;
            nxt_ff.count  = '0;
        end
    end

    // State register, reset clears memory contents too
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_ff;
        end
    end

endmodule : card_rx_fifo

// ==== rtl/card_rd_dma.sv ====
// Summary of operation
// - DMA channel uses hardware handshake; this block paces it by request.
// - Word descriptor count is length over four; zero count is skipped.
// - Control B written zero; pointer chooses word or byte descriptor.
// - Round option 1 moves an odd length as whole padded words.
// - A command leaves as soon as the command register is written.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "card_rd_dma_params.svh"

module card_rd_dma (
    // Clock and reset
    input  wire logic                       REF_CLK_I,
    input  wire logic                       RESET_N_I,
    // Register port
    input  wire logic [`CRD_ADDR_W-1:0]     REG_ADDR_I,
    input  wire logic [`CRD_DATA_W-1:0]     REG_WDATA_I,
    input  wire logic                       REG_WR_I,
    input  wire logic                       REG_RD_I,
    output logic      [`CRD_DATA_W-1:0]     REG_RDATA_O,
    // Card command side
    output logic                            CMD_START_O,
    output logic      [`CRD_CMD_IDX_W-1:0]  CMD_INDEX_O,
    output logic      [31:0]                CMD_ARG_O,
    input  wire logic                       CMD_DONE_I,
    input  wire logic                       CARD_BUSY_I,
    // Card receive data
    input  wire logic                       CARD_BYTE_VALID_I,
    input  wire logic [7:0]                 CARD_BYTE_I,
    output logic                            CARD_STALL_O,
    // DMA hardware handshake
    output logic                            DMA_REQ_O
);

    localparam int AW = `CRD_FIFO_AW;

    card_rd_dma_pkg::host_state_t st_ff;
    card_rd_dma_pkg::host_state_t nxt_ff;

    logic [31:0] fifo_data;
    logic [AW:0] fifo_count;
    logic        fifo_full;
    logic        fifo_empty;
    logic        fifo_push;
    logic        fifo_pop;
    logic        fifo_flush;
    logic [31:0] push_word;
    logic        rx_done;
    logic        last_part;
    logic        byte_take;
    logic        start_read;
    logic [AW:0] chunk_words;
    logic [31:0] head_shift;

    // Chunk size field is log2 of the word count
    function automatic logic [AW:0] chunk_to_words(input logic [2:0] code);
        chunk_to_words = (AW+1)'(1) << code;
    endfunction : chunk_to_words

    card_rx_fifo #(
        .W  (32),
        .AW (AW)
    ) u_rx_fifo (
        .clk_i       (REF_CLK_I),
        .rst_n_i     (RESET_N_I),
        .flush_i     (fifo_flush),
        .push_i      (fifo_push),
        .push_data_i (push_word),
        .pop_i       (fifo_pop),
        .data_o      (fifo_data),
        .count_o     (fifo_count),
        .full_o      (fifo_full),
        .empty_o     (fifo_empty)
    );

    // Derived conditions of the receive path
    assign rx_done     = (st_ff.rx_bytes == st_ff.cfg.blk_len);
    assign chunk_words = chunk_to_words(st_ff.cfg.dma_chunk_size);
    assign head_shift  = fifo_data >> {st_ff.byte_idx, 3'b000};
    assign last_part   = rx_done && (fifo_count == (AW+1)'(1))
                         && (st_ff.cfg.blk_len[1:0] != 2'b00)
                         && !st_ff.cfg.read_round_option;
    assign CARD_STALL_O = st_ff.rx_active && fifo_full && st_ff.cfg.read_stall_proof;
    assign byte_take    = CARD_BYTE_VALID_I && st_ff.rx_active && !rx_done && !CARD_STALL_O;
    assign DMA_REQ_O   = st_ff.rx_active && st_ff.cfg.dma_handshake_enable && !fifo_empty
                         && ((fifo_count >= chunk_words) || rx_done);

    // Outputs from the state register
    assign REG_RDATA_O = st_ff.rdata;
    assign CMD_START_O = st_ff.cmd_start;
    assign CMD_INDEX_O = st_ff.cmd_index;
    assign CMD_ARG_O   = st_ff.cmd_arg;

    // Next state: register access, byte packing, completion
    always_comb
    begin
        nxt_ff                = st_ff;
        nxt_ff.cmd_start      = 1'b0;
        nxt_ff.rdata          = '0;
        nxt_ff.card_idle_flag = !CARD_BUSY_I;
        fifo_push             = 1'b0;
        fifo_pop              = 1'b0;
        start_read            = 1'b0;
        push_word             = st_ff.pack_data | (32'(CARD_BYTE_I) << {st_ff.pack_cnt, 3'b000});
        if (REG_WR_I)
        begin
            unique case (REG_ADDR_I)
                `CRD_OFS_MODE:
                begin
                    nxt_ff.cfg.blk_len          = REG_WDATA_I[`CRD_MODE_LEN_W-1:0];
                    nxt_ff.cfg.read_stall_proof = REG_WDATA_I[`CRD_MODE_PROOF_BIT];
                end
                `CRD_OFS_DMA:
                begin
                    nxt_ff.cfg.dma_offset           = REG_WDATA_I[`CRD_DMA_OFS_LSB +: 2];
                    nxt_ff.cfg.dma_chunk_size       =
                        REG_WDATA_I[`CRD_DMA_CHUNK_LSB +: `CRD_DMA_CHUNK_W];
                    nxt_ff.cfg.dma_handshake_enable = REG_WDATA_I[`CRD_DMA_EN_BIT];
                    nxt_ff.cfg.read_round_option    = REG_WDATA_I[`CRD_DMA_READ_ROUND_OPTION_BIT];
                end
                `CRD_OFS_ARG:
                begin
                    nxt_ff.cmd_arg = REG_WDATA_I;
                end
                `CRD_OFS_CMD:
                begin
                    nxt_ff.cmd_index          = REG_WDATA_I[`CRD_CMD_IDX_W-1:0];
                    nxt_ff.cmd_start          = 1'b1;
                    nxt_ff.command_ready_flag = 1'b0;
                    start_read                = REG_WDATA_I[`CRD_CMD_READ_BIT];
                end
                default:
                begin
                    // Unmapped or read-only: write ignored
                end
            endcase
        end
        // A data command restarts the whole receive path
        if (start_read)
        begin
            nxt_ff.rx_active          = 1'b1;
            nxt_ff.rx_bytes           = '0;
            nxt_ff.pack_data          = '0;
            nxt_ff.pack_cnt           = 2'b00;
            nxt_ff.byte_idx           = 2'b00;
            nxt_ff.transfer_done_flag = 1'b0;
            nxt_ff.overrun_flag       = 1'b0;
        end
        if (REG_RD_I)
        begin
            unique case (REG_ADDR_I)
                `CRD_OFS_MODE:
                begin
                    nxt_ff.rdata[`CRD_MODE_LEN_LSB +: `CRD_MODE_LEN_W] = st_ff.cfg.blk_len;
                    nxt_ff.rdata[`CRD_MODE_PROOF_BIT] = st_ff.cfg.read_stall_proof;
                end
                `CRD_OFS_DMA:
                begin
                    nxt_ff.rdata[`CRD_DMA_OFS_LSB +: 2] = st_ff.cfg.dma_offset;
                    nxt_ff.rdata[`CRD_DMA_CHUNK_LSB +: `CRD_DMA_CHUNK_W] =
                        st_ff.cfg.dma_chunk_size;
                    nxt_ff.rdata[`CRD_DMA_EN_BIT]   = st_ff.cfg.dma_handshake_enable;
                    nxt_ff.rdata[`CRD_DMA_READ_ROUND_OPTION_BIT] = st_ff.cfg.read_round_option;
                end
                `CRD_OFS_ARG:
                begin
                    nxt_ff.rdata = st_ff.cmd_arg;
                end
                `CRD_OFS_STATUS:
                begin
                    nxt_ff.rdata[`CRD_ST_COMMAND_READY_FLAG_BIT] = st_ff.command_ready_flag;
                    nxt_ff.rdata[`CRD_ST_IDLE_BIT]   = st_ff.card_idle_flag;
                    nxt_ff.rdata[`CRD_ST_DONE_BIT]   = st_ff.transfer_done_flag;
                    nxt_ff.rdata[`CRD_ST_EMPTY_BIT]  = fifo_empty;
                    nxt_ff.rdata[`CRD_ST_OVR_BIT]    = st_ff.overrun_flag;
                    nxt_ff.rdata[`CRD_ST_REQ_BIT]    = DMA_REQ_O;
                end
                `CRD_OFS_FIFO:
                begin
                    if (!fifo_empty && last_part)
                    begin
                        // one byte per read, low lane
                        nxt_ff.rdata[7:0] = head_shift[7:0];
                        nxt_ff.byte_idx   = st_ff.byte_idx + 2'b01;
                        if ((st_ff.byte_idx + 2'b01) == st_ff.cfg.blk_len[1:0])
                        begin
                            fifo_pop        = 1'b1;
                            nxt_ff.byte_idx = 2'b00;
                        end
                    end
                    else if (!fifo_empty)
                    begin
                        // whole or padded word read as one word
                        nxt_ff.rdata = fifo_data;
                        fifo_pop     = 1'b1;
                    end
                end
                default:
                begin
                    // Unmapped or write-only: reads as zero
                end
            endcase
        end
        // Pack card bytes little-endian; a short tail is zero padded
        if (byte_take)
        begin
            nxt_ff.rx_bytes  = st_ff.rx_bytes + 16'h0001;
            nxt_ff.pack_data = push_word;
            nxt_ff.pack_cnt  = st_ff.pack_cnt + 2'b01;
            if ((st_ff.pack_cnt == 2'b11) || ((st_ff.rx_bytes + 16'h0001) == st_ff.cfg.blk_len))
            begin
                nxt_ff.pack_data = '0;
                nxt_ff.pack_cnt  = 2'b00;
                fifo_push        = !fifo_full;
                if (fifo_full)
                begin
                    nxt_ff.overrun_flag = 1'b1;
                end
            end
        end
        if (st_ff.rx_active && rx_done && fifo_empty)
        begin
            nxt_ff.transfer_done_flag = 1'b1;
            if (!start_read)
            begin
                nxt_ff.rx_active = 1'b0;
            end
        end
        // Response end sets ready; wins over a same-cycle clear
        if (CMD_DONE_I)
        begin
            nxt_ff.command_ready_flag = 1'b1;
        end
    end

    assign fifo_flush = start_read;

    // Synchronous reset to constants only
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            st_ff                    <= '0;
            st_ff.command_ready_flag <= `CRD_RST_CMD_READY;
            st_ff.card_idle_flag     <= `CRD_RST_CARD_IDLE;
        end
        else
        begin
            st_ff <= nxt_ff;
        end
    end

endmodule : card_rd_dma

// ==== tb/card_rd_dma_props.sv ====
`timescale 1ns/100ps
`include "card_rd_dma_params.svh"

module card_rd_dma_props (
    // Clock and reset
    input wire logic                      REF_CLK_I,
    input wire logic                      RESET_N_I,
    // Register port
    input wire logic [`CRD_ADDR_W-1:0]    REG_ADDR_I,
    input wire logic [`CRD_DATA_W-1:0]    REG_WDATA_I,
    input wire logic                      REG_WR_I,
    input wire logic                      REG_RD_I,
    input wire logic [`CRD_DATA_W-1:0]    REG_RDATA_O,
    // Command, card and handshake
    input wire logic                      CMD_START_O,
    input wire logic [`CRD_CMD_IDX_W-1:0] CMD_INDEX_O,
    input wire logic [31:0]               CMD_ARG_O,
    input wire logic                      CARD_STALL_O,
    input wire logic                      DMA_REQ_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    logic en_ff;
    logic proof_ff;

    // Shadow of enable and proof bits, so outputs can be judged against them
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            en_ff    <= 1'b0;
            proof_ff <= 1'b0;
        end
        else if (REG_WR_I && REG_ADDR_I == `CRD_OFS_DMA)
            en_ff <= REG_WDATA_I[`CRD_DMA_EN_BIT];
        else if (REG_WR_I && REG_ADDR_I == `CRD_OFS_MODE)
            proof_ff <= REG_WDATA_I[`CRD_MODE_PROOF_BIT];
    end

    a_cmd_start_issue: assert property (REG_WR_I && REG_ADDR_I == `CRD_OFS_CMD |=> CMD_START_O)
        else $error("command start missing after command write");
    a_start_has_cause: assert property (CMD_START_O |-> $past(REG_WR_I) && $past(REG_ADDR_I) == `CRD_OFS_CMD)
        else $error("command start without command write");
    a_cmd_index_load: assert property (REG_WR_I && REG_ADDR_I == `CRD_OFS_CMD
        |=> CMD_INDEX_O == $past(REG_WDATA_I[`CRD_CMD_IDX_W-1:0]))
        else $error("command index not loaded");
    a_arg_load: assert property (REG_WR_I && REG_ADDR_I == `CRD_OFS_ARG |=> CMD_ARG_O == $past(REG_WDATA_I))
        else $error("command argument not loaded");
    a_req_needs_en: assert property (!en_ff |-> !DMA_REQ_O)
        else $error("request while handshake disabled");
    a_stall_needs_proof: assert property (CARD_STALL_O |-> proof_ff)
        else $error("stall while stall proof is off");
    a_status_req_bit: assert property (REG_RD_I && REG_ADDR_I == `CRD_OFS_STATUS
        |=> REG_RDATA_O[`CRD_ST_REQ_BIT] == $past(DMA_REQ_O))
        else $error("status request bit differs from request");
    a_done_when_empty: assert property (REG_RD_I && REG_ADDR_I == `CRD_OFS_STATUS
        |=> !REG_RDATA_O[`CRD_ST_DONE_BIT] || REG_RDATA_O[`CRD_ST_EMPTY_BIT])
        else $error("done reported with data left in FIFO");
    a_rdata_idle_zero: assert property (!REG_RD_I |=> REG_RDATA_O == '0)
        else $error("read data not zero outside read answer");

    c_cmd_start: cover property (CMD_START_O);
    c_req_drop: cover property (DMA_REQ_O ##1 !DMA_REQ_O);
    c_stall: cover property (CARD_STALL_O);
endmodule : card_rd_dma_props

bind card_rd_dma card_rd_dma_props i_card_rd_dma_props (
    .REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .CMD_START_O(CMD_START_O), .CMD_INDEX_O(CMD_INDEX_O),
    .CMD_ARG_O(CMD_ARG_O), .CARD_STALL_O(CARD_STALL_O), .DMA_REQ_O(DMA_REQ_O));

// ==== tb/dma_chan_model.sv ====
`timescale 1ns/100ps

module dma_chan_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Channel setup
    input  wire logic        go_i,
    input  wire logic        slow_i,
    input  wire logic [15:0] n_rd_i,
    // Handshake and read data
    input  wire logic        req_i,
    input  wire logic [31:0] rdata_i,
    output logic             rd_o,
    output logic             busy_o
);
    logic [31:0] mem [0:63];
    logic [15:0] left;
    logic [5:0]  idx;
    logic [3:0]  gap;
    logic        cap;

    // Busy until the last answer is captured
    assign busy_o = (left != 16'h0000) || rd_o || cap;

    // reads only on request, store ascending
    // fresh channel, word then byte chain
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rd_o <= 1'b0;
            cap  <= 1'b0;
            left <= 16'h0000;
            idx  <= 6'h00;
            gap  <= 4'h0;
        end
        else
        begin
            rd_o <= 1'b0;
            cap  <= rd_o;
            if (gap != 4'h0)
                gap <= gap - 4'h1;
            if (cap)
            begin
                mem[idx] <= rdata_i;
                idx      <= idx + 6'h01;
                gap      <= slow_i ? 4'hc : 4'h0;  // Slow memory side backs up FIFO
            end
            if (go_i)
            begin
                left <= n_rd_i;
                idx  <= 6'h00;
            end
            else if (req_i && !rd_o && !cap && gap == 4'h0 && left != 16'h0000)
            begin
                rd_o <= 1'b1;
                left <= left - 16'h0001;
            end
        end
    end
endmodule : dma_chan_model

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`include "card_rd_dma_params.svh"

module tb_top;
    int          err_count = 0;
    int          samples_checked = 0;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    logic [7:0]  sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0;
    logic        cmd_done = 1'b0;
    logic        card_busy = 1'b1;
    logic        card_v = 1'b0;
    logic [7:0]  card_b = 8'h00;
    logic        dma_go = 1'b0;
    logic        slow = 1'b0;
    logic [15:0] n_rd = 16'h0;
    logic        stall_seen = 1'b0;
    logic        dma_rd, dma_busy, stall, req;
    logic [31:0] rdata;

    // Clock
    always #2.5 ref_clk = ~ref_clk;

    // Channel reads share the register port; software stays off it meanwhile
    card_rd_dma i_card_rd_dma (.REF_CLK_I(ref_clk), .RESET_N_I(reset_n),
        .REG_ADDR_I(dma_rd ? `CRD_OFS_FIFO : sw_addr), .REG_WDATA_I(sw_wdata),
        .REG_WR_I(sw_wr), .REG_RD_I(sw_rd | dma_rd), .REG_RDATA_O(rdata),
        .CMD_START_O(), .CMD_INDEX_O(), .CMD_ARG_O(), .CMD_DONE_I(cmd_done),
        .CARD_BUSY_I(card_busy), .CARD_BYTE_VALID_I(card_v), .CARD_BYTE_I(card_b),
        .CARD_STALL_O(stall), .DMA_REQ_O(req));
    dma_chan_model i_dma_chan_model (.clk_i(ref_clk), .rst_n_i(reset_n), .go_i(dma_go),
        .slow_i(slow), .n_rd_i(n_rd), .req_i(req), .rdata_i(rdata), .rd_o(dma_rd),
        .busy_o(dma_busy));

    always @(posedge ref_clk) if (stall) stall_seen <= 1'b1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("checked=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        sw_wr <= 1'b1; sw_addr <= a; sw_wdata <= d;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        sw_rd <= 1'b1; sw_addr <= a;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask : rd

    function automatic logic [7:0] bval(input int i);
        return 8'(i * 7 + 3);
    endfunction : bval

    // Little-endian packing, tail zero padded
    function automatic logic [31:0] word_at(input int k, input int len);
        logic [31:0] w;
        w = 32'h0;
        for (int j = 0; j < 4; j++)
            if (4 * k + j < len) w[8*j+:8] = bval(4 * k + j);
        return w;
    endfunction : word_at

    // Card sends bytes, holding each while stalled
    task automatic feed(input int len);
        @(posedge ref_clk);
        for (int i = 0; i < len; i++)
        begin
            card_v <= 1'b1; card_b <= bval(i);
            @(negedge ref_clk);
            while (stall) @(negedge ref_clk);
            @(posedge ref_clk);
        end
        card_v <= 1'b0; card_b <= ~card_b;
    endtask : feed

    task automatic t_reset;
        logic [31:0] d;
        rd(`CRD_OFS_STATUS, d);
        check(d, 32'h0000_0009);
        card_busy <= 1'b0;
        rd(8'hfc, d);
        check(d, 32'h0);
        rd(`CRD_OFS_STATUS, d);
        check(d, 32'h0000_000b);
        $display("test reset done");
    endtask : t_reset

    task automatic run(input int len, input bit rop, input logic [2:0] chk, input bit sl);
        logic [31:0] d;
        int n;
        n = rop ? (len + 3) / 4 : len / 4 + len % 4;
        wr(`CRD_OFS_MODE, 32'h0001_0000 | len);
        wr(`CRD_OFS_DMA, {19'h0, rop, 5'h0, chk, 4'h0});
        wr(`CRD_OFS_DMA, {19'h0, rop, 3'h0, 1'b1, 1'b0, chk, 4'h0});
        wr(`CRD_OFS_ARG, 32'h0000_1200 + len);
        wr(`CRD_OFS_CMD, 32'h0000_0111);
        rd(`CRD_OFS_STATUS, d);
        check(d, 32'h0000_000a);
        @(posedge ref_clk);
        cmd_done <= 1'b1; n_rd <= 16'(n); slow <= sl; dma_go <= 1'b1; stall_seen <= 1'b0;
        @(posedge ref_clk);
        cmd_done <= 1'b0; dma_go <= 1'b0;
        feed(len);
        for (int k = 0; k < 3000 && dma_busy; k++) @(posedge ref_clk);
        check({31'h0, dma_busy}, 32'h0);
        repeat (2) @(posedge ref_clk);
        rd(`CRD_OFS_STATUS, d);
        check(d, 32'h0000_000f);
        // words first, then single bytes in low lane
        for (int k = 0; k < n; k++)
            if (rop || k < len / 4)
                check(i_dma_chan_model.mem[k], word_at(k, len));
            else
                check({24'h0, i_dma_chan_model.mem[k][7:0]}, {24'h0, bval(len / 4 * 4 + k - len / 4)});
        if (sl) check({31'h0, stall_seen}, 32'h1);
        $display("test len=%0d round=%0d done", len, rop);
    endtask : run

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        results();
    end

    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        run(16, 1'b0, 3'h2, 1'b0);
        run(110, 1'b0, 3'h0, 1'b1);
        run(3, 1'b0, 3'h1, 1'b0);
        run(10, 1'b1, 3'h1, 1'b0);
        results();
    end
endmodule : tb_top
